// ---- pkg/pfs_pkg.sv ----
package pfs_pkg;

  // ==========================================================================
  // Command codes of the status reads.
  // ==========================================================================
  localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_STATUS = 8'h7c;
  localparam logic [7:0] CMD_TEMPERATURE_STATUS = 8'h7d;
  localparam logic [7:0] CMD_COMM_LOGIC_MEMORY_STATUS = 8'h7e;

  // ==========================================================================
  // Bit positions.
  // ==========================================================================
  localparam int OVERCURRENT_FAULT_BIT = 7;
  localparam int OVERCURRENT_WARNING_BIT = 5;
  localparam int UNDERCURRENT_FAULT_BIT = 4;
  localparam int HIGH_FAULT_BIT = 7;
  localparam int HIGH_WARNING_BIT = 6;
  localparam int LOW_WARNING_BIT = 5;
  localparam int LOW_FAULT_BIT = 4;
  localparam int BAD_COMMAND_BIT = 7;
  localparam int BAD_DATA_BIT = 6;
  localparam int PEC_FAIL_BIT = 5;
  localparam int ACCESS_ERROR_BIT = 1;
  localparam int SUMMARY_OTHER_BIT = 9;
  localparam int SUMMARY_CML_BIT = 1;

  // ==========================================================================
  // Reset values and used-bit masks.
  // ==========================================================================
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CURRENT_MASK = 8'hb0;
  localparam logic [7:0] RANGE_MASK = 8'hf0;
  localparam logic [7:0] COMM_MASK = 8'he2;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;

  // Four events of one monitored quantity.
  typedef struct packed {
    logic high_fault;
    logic high_warning;
    logic low_warning;
    logic low_fault;
  } pfs_range_t;

  // Events from the bus command decoder, one-cycle pulses.
  typedef struct packed {
    logic bad_command;
    logic bad_data;
    logic pec_fail;
    logic access_error;
  } pfs_comm_t;

  // One read request of the command decoder.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } pfs_read_req_t;

endpackage

// ---- hdl/pfs_sticky_byte.sv ----
// ==========================================================================
// One status byte of sticky flags.
// ==========================================================================
module pfs_sticky_byte #(
  parameter logic [7:0] USED_MASK = 8'hff
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [7:0] set_bits,
  output logic [7:0] flags_q
);

  logic [7:0] flags_d;

  // A byte without any used bit would be a dead register.
  if (USED_MASK == 8'h00) begin : g_mask_check
    $error("pfs_sticky_byte needs at least one used bit");
  end

  // A set in the cycle of a clear wins; unused bits stay zero.
  assign flags_d = ((clear ? 8'h00 : flags_q) | set_bits) & USED_MASK;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= pfs_pkg::STATUS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// ---- hdl/pfs_status_regs.sv ----
// What this block does
// - Overcurrent fault sets current status bit 7.
// - Overcurrent warning sets current bit 5, but not alongside an overcurrent fault.
// - Undercurrent fault sets current status bit 4.
// - Input overvoltage fault sets input status bit 7.
// - Input overvoltage warning sets input bit 6, not alongside its fault.
// - Input undervoltage warning sets input bit 5, not alongside its fault.
// - Input undervoltage fault sets input status bit 4.
// - Over-temperature fault sets temperature status bit 7.
// - Over-temperature warning sets temperature bit 6, not alongside its fault.
// - Under-temperature warning sets temperature bit 5, not alongside its fault.
// - Under-temperature fault sets temperature status bit 4.
// - Invalid or unsupported command code sets communications bit 7.
// - Command with invalid or unsupported data sets communications bit 6.
// - Packet error check mismatch sets communications bit 5.
// - Write to protected command or wrong byte count sets communications bit 1.
// - Flags hold until clear-faults command or disable then re-enable.
// - A fault bit may be set while its warning bit stays clear.
// - Each register is one read-only byte resetting to zero.
// - Summary word bit 9 is set whenever any of these bits is set.
// - Summary word bit 1 is set whenever a communications flag is set.
module pfs_status_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic overcurrent_fault,
  input wire logic overcurrent_warning,
  input wire logic undercurrent_fault,
  input wire pfs_pkg::pfs_range_t input_voltage_events,
  input wire pfs_pkg::pfs_range_t temperature_events,
  input wire pfs_pkg::pfs_comm_t comm_events,
  input wire logic clear_faults,
  input wire logic unit_enable,
  input wire pfs_pkg::pfs_read_req_t read_req,
  output logic read_valid_q,
  output logic read_hit_q,
  output logic [7:0] read_data_q,
  output logic [15:0] summary_word_q
);

  // ==========================================================================
  // Clear sources.
  // ==========================================================================
  logic enable_q;
  logic reenable;
  logic clear_all;

  // Disable-then-enable is seen as the rising edge of the enable level.
  assign reenable = unit_enable & ~enable_q;
  assign clear_all = clear_faults | reenable;

  // Reset to the enabled level so that the release of reset is no false re-enable.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b1;
    end else begin
      enable_q <= unit_enable;
    end
  end

  // ==========================================================================
  // Set terms. A warning is suppressed while its fault is present.
  // ==========================================================================
  logic [7:0] current_set;
  logic [7:0] input_set;
  logic [7:0] temp_set;
  logic [7:0] comm_set;

  // The warning gate below is why a fault may stand with its warning clear.
  always_comb begin
    current_set = 8'h00;
    current_set[pfs_pkg::OVERCURRENT_FAULT_BIT] = overcurrent_fault;
    current_set[pfs_pkg::OVERCURRENT_WARNING_BIT] =
      overcurrent_warning & ~overcurrent_fault;
    current_set[pfs_pkg::UNDERCURRENT_FAULT_BIT] = undercurrent_fault;
  end

  always_comb begin
    input_set = 8'h00;
    input_set[pfs_pkg::HIGH_FAULT_BIT] = input_voltage_events.high_fault;
    input_set[pfs_pkg::HIGH_WARNING_BIT] =
      input_voltage_events.high_warning & ~input_voltage_events.high_fault;
    input_set[pfs_pkg::LOW_WARNING_BIT] =
      input_voltage_events.low_warning & ~input_voltage_events.low_fault;
    input_set[pfs_pkg::LOW_FAULT_BIT] = input_voltage_events.low_fault;
  end

  always_comb begin
    temp_set = 8'h00;
    temp_set[pfs_pkg::HIGH_FAULT_BIT] = temperature_events.high_fault;
    temp_set[pfs_pkg::HIGH_WARNING_BIT] =
      temperature_events.high_warning & ~temperature_events.high_fault;
    temp_set[pfs_pkg::LOW_WARNING_BIT] =
      temperature_events.low_warning & ~temperature_events.low_fault;
    temp_set[pfs_pkg::LOW_FAULT_BIT] = temperature_events.low_fault;
  end

  always_comb begin
    comm_set = 8'h00;
    comm_set[pfs_pkg::BAD_COMMAND_BIT] = comm_events.bad_command;
    comm_set[pfs_pkg::BAD_DATA_BIT] = comm_events.bad_data;
    comm_set[pfs_pkg::PEC_FAIL_BIT] = comm_events.pec_fail;
    comm_set[pfs_pkg::ACCESS_ERROR_BIT] = comm_events.access_error;
  end

  // ==========================================================================
  // Sticky registers; unused bits masked to zero.
  // ==========================================================================
  localparam logic [3:0][7:0] USED_MASKS = {pfs_pkg::COMM_MASK, pfs_pkg::RANGE_MASK,
    pfs_pkg::RANGE_MASK, pfs_pkg::CURRENT_MASK};

  logic [3:0][7:0] status_set;
  logic [3:0][7:0] status_flags;
  logic [7:0] output_current_status;
  logic [7:0] input_voltage_status;
  logic [7:0] temperature_status;
  logic [7:0] comm_logic_memory_status;

  assign status_set = {comm_set, temp_set, input_set, current_set};
  assign output_current_status = status_flags[0];
  assign input_voltage_status = status_flags[1];
  assign temperature_status = status_flags[2];
  assign comm_logic_memory_status = status_flags[3];

  for (genvar g = 0; g < 4; g++) begin : g_status_byte
    pfs_sticky_byte #(.USED_MASK(USED_MASKS[g])) u_pfs_sticky_byte (
      .core_clk(core_clk),
      .resetn(resetn),
      .clear(clear_all),
      .set_bits(status_set[g]),
      .flags_q(status_flags[g])
    );
  end

  // ==========================================================================
  // Read decode and summary.
  // ==========================================================================
  logic hit_current;
  logic hit_input;
  logic hit_temp;
  logic hit_comm;
  logic read_hit_d;
  logic [7:0] read_data_d;
  logic [15:0] summary_word_d;
  logic any_flag;
  logic comm_logic_memory_summary_flag;

  assign hit_current = read_req.code == pfs_pkg::CMD_OUTPUT_CURRENT_STATUS;
  assign hit_input = read_req.code == pfs_pkg::CMD_INPUT_VOLTAGE_STATUS;
  assign hit_temp = read_req.code == pfs_pkg::CMD_TEMPERATURE_STATUS;
  assign hit_comm = read_req.code == pfs_pkg::CMD_COMM_LOGIC_MEMORY_STATUS;
  assign read_hit_d = read_req.valid & (hit_current | hit_input | hit_temp | hit_comm);

  // Registers are read-only: there is no write path at all.
  assign read_data_d = !read_req.valid ? read_data_q :
    ({8{hit_current}} & output_current_status) |
    ({8{hit_input}} & input_voltage_status) |
    ({8{hit_temp}} & temperature_status) |
    ({8{hit_comm}} & comm_logic_memory_status);

  assign any_flag = |{output_current_status, input_voltage_status,
                      temperature_status, comm_logic_memory_status};
  assign comm_logic_memory_summary_flag = |comm_logic_memory_status;

  always_comb begin
    summary_word_d = pfs_pkg::SUMMARY_RESET;
    summary_word_d[pfs_pkg::SUMMARY_OTHER_BIT] = any_flag;
    summary_word_d[pfs_pkg::SUMMARY_CML_BIT] = comm_logic_memory_summary_flag;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      read_valid_q <= 1'b0;
      read_hit_q <= 1'b0;
      read_data_q <= pfs_pkg::STATUS_RESET;
      summary_word_q <= pfs_pkg::SUMMARY_RESET;
    end else begin
      read_valid_q <= read_req.valid;
      read_hit_q <= read_hit_d;
      read_data_q <= read_data_d;
      summary_word_q <= summary_word_d;
    end
  end

endmodule

// ---- verif/pfs_status_regs_properties.sv ----
// ==========================================================================
// Port-level checks of the status byte bank.
// ==========================================================================
module pfs_status_regs_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic overcurrent_fault,
  input wire pfs_pkg::pfs_comm_t comm_events,
  input wire pfs_pkg::pfs_read_req_t read_req,
  input wire logic read_valid_q,
  input wire logic read_hit_q,
  input wire logic [7:0] read_data_q,
  input wire logic [15:0] summary_word_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_READ_PULSE: assert property (read_req.valid |=> read_valid_q)
    else $error("read answer missing");
  AST_READ_HOLD: assert property (!read_req.valid |=>
    !read_valid_q && $stable(read_data_q))
    else $error("read output moved without a read");
  AST_HIT: assert property (read_req.valid |=>
    read_hit_q == ($past(read_req.code) inside {[8'h7b:8'h7e]}))
    else $error("read hit wrong");
  AST_MISS_ZERO: assert property (read_valid_q && !read_hit_q |-> read_data_q == 8'h00)
    else $error("unmapped read not zero");
  AST_OC_FAULT: assert property (overcurrent_fault ##1
    (read_req.valid && read_req.code == 8'h7b) |=> read_data_q[7])
    else $error("overcurrent fault not reported");
  AST_CUR_UNUSED: assert property (read_req.valid && read_req.code == 8'h7b |=>
    (read_data_q & 8'h4f) == 8'h00)
    else $error("current unused bits set");
  AST_CML_UNUSED: assert property (read_req.valid && read_req.code == 8'h7e |=>
    (read_data_q & 8'h1d) == 8'h00)
    else $error("comm unused bits set");
  AST_SUM_UNUSED: assert property ((summary_word_q & 16'hfdfd) == 16'h0000)
    else $error("summary unused bits set");
  AST_SUM_ANY: assert property (overcurrent_fault |-> ##2 summary_word_q[9])
    else $error("summary any-flag bit missing");
  AST_SUM_CML: assert property (comm_events.bad_command |-> ##2 summary_word_q[1])
    else $error("summary comm bit missing");
endmodule

bind pfs_status_regs pfs_status_regs_properties u_pfs_status_regs_properties (
  .core_clk(core_clk),
  .resetn(resetn),
  .overcurrent_fault(overcurrent_fault),
  .comm_events(comm_events),
  .read_req(read_req),
  .read_valid_q(read_valid_q),
  .read_hit_q(read_hit_q),
  .read_data_q(read_data_q),
  .summary_word_q(summary_word_q)
);

// ---- verif/pfs_host_model.sv ----
// ==========================================================================
// Bus host that issues one status read at a time.
// ==========================================================================
module pfs_host_model (
  input wire logic core_clk,
  output pfs_pkg::pfs_read_req_t read_req,
  input wire logic read_valid_q,
  input wire logic read_hit_q,
  input wire logic [7:0] read_data_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial read_req = '{valid: 1'b0, code: 8'h00};
  // Returns {valid, hit, data}; a released code shows its inverse.
  task automatic read(input logic [7:0] c, output logic [15:0] r);
    read_req = '{valid: 1'b1, code: c};
    @(posedge core_clk);
    #1;
    r = {6'h00, read_valid_q, read_hit_q, read_data_q};
    read_req = '{valid: 1'b0, code: ~c};
    @(posedge core_clk);
    #1;
  endtask
endmodule

// ---- verif/tb_pfs_status_regs.sv ----
// ==========================================================================
// Self-checking bench of the status byte bank.
// ==========================================================================
module tb_pfs_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic unit_enable = 1'b1;
  logic clear_faults = 1'b0;
  logic [14:0] ev = 15'h0000;
  logic read_valid_q;
  logic read_hit_q;
  logic [7:0] read_data_q;
  logic [15:0] summary_word_q;
  pfs_pkg::pfs_read_req_t read_req;
  int bad_count = 0;
  int checks = 0;
  always #12.5 core_clk = ~core_clk;
  pfs_status_regs u_pfs_status_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .overcurrent_fault(ev[14]),
    .overcurrent_warning(ev[13]),
    .undercurrent_fault(ev[12]),
    .input_voltage_events(ev[11:8]),
    .temperature_events(ev[7:4]),
    .comm_events(ev[3:0]),
    .clear_faults(clear_faults),
    .unit_enable(unit_enable),
    .read_req(read_req),
    .read_valid_q(read_valid_q),
    .read_hit_q(read_hit_q),
    .read_data_q(read_data_q),
    .summary_word_q(summary_word_q)
  );
  pfs_host_model u_pfs_host_model (
    .core_clk(core_clk),
    .read_req(read_req),
    .read_valid_q(read_valid_q),
    .read_hit_q(read_hit_q),
    .read_data_q(read_data_q)
  );
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fire(input logic [14:0] v);
    ev = v;
    @(posedge core_clk);
    #1;
    ev = 15'h0000;
  endtask
  task automatic clr;
    clear_faults = 1'b1;
    @(posedge core_clk);
    #1;
    clear_faults = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset;
    logic [15:0] r;
    for (int c = 8'h7a; c <= 8'h7f; c++) begin
      u_pfs_host_model.read(8'(c), r);
      chk("reset read", (c > 8'h7a && c < 8'h7f) ? 16'h0300 : 16'h0200, r);
    end
    chk("reset summary", 16'h0000, summary_word_q);
  endtask
  task automatic t_bits;
    logic [15:0] r;
    logic [7:0] d;
    logic [7:0] c;
    for (int i = 0; i < 15; i++) begin
      c = i < 4 ? 8'h7e : i < 8 ? 8'h7d : i < 12 ? 8'h7c : 8'h7b;
      d = (i == 0) ? 8'h02 : (i == 14) ? 8'h80 : 8'h10 << (i % 4);
      fire(15'h0001 << i);
      u_pfs_host_model.read(c, r);
      chk("flag read", {8'h03, d}, r);
      chk("summary", i < 4 ? 16'h0202 : 16'h0200, summary_word_q);
      u_pfs_host_model.read(c, r);
      chk("flag held", {8'h03, d}, r);
      clr;
      u_pfs_host_model.read(c, r);
      chk("flag cleared", 16'h0300, r);
    end
  endtask
  task automatic t_warn;
    logic [15:0] r;
    fire(15'h6ff0);
    for (int c = 8'h7b; c < 8'h7e; c++) begin
      u_pfs_host_model.read(8'(c), r);
      chk("warn masked", c == 8'h7b ? 16'h0380 : 16'h0390, r);
    end
    clr;
  endtask
  task automatic t_enable;
    logic [15:0] r;
    fire(15'h0008);
    unit_enable = 1'b0;
    u_pfs_host_model.read(8'h7e, r);
    chk("held while off", 16'h0380, r);
    unit_enable = 1'b1;
    @(posedge core_clk);
    #1;
    u_pfs_host_model.read(8'h7e, r);
    chk("re-enable clear", 16'h0300, r);
  endtask
  task automatic t_midreset;
    logic [15:0] r;
    fire(15'h4008);
    resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("summary in reset", 16'h0000, summary_word_q);
    resetn = 1'b1;
    u_pfs_host_model.read(8'h7b, r);
    chk("flags after reset", 16'h0300, r);
    u_pfs_host_model.read(8'h7e, r);
    chk("comm after reset", 16'h0300, r);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_reset;
    t_bits;
    t_warn;
    t_enable;
    t_midreset;
    tally_and_finish;
  end
  initial begin
    #50000;
    bad_count++;
    tally_and_finish;
  end
endmodule
